// file: src/liu_global_template_alarm_regs.sv
//----------------------------------------------------------------------------
// Purpose: Global, template, driver and alarm registers of the line unit.
// Assumes: Host strobes are one-cycle pulses synchronous to ref_clk.
// Notes:   Expanded-bank registers live elsewhere; this bank yields to them.
//----------------------------------------------------------------------------
`timescale 1ns/1ps

module liu_global_template_alarm_regs #(
    parameter int CHANNELS = 8
) (
    input  wire logic                             ref_clk,
    input  wire logic                             nrst,
    input  wire logic                             ce,
    input  wire liu_regs_pkg::host_req_t          hostReq,
    output logic      [liu_regs_pkg::DATA_W-1:0]  rdData,
    output logic                                  rdValid,
    output logic                                  rdHit,
    output logic                                  expandedBankSel,
    input  wire logic [CHANNELS-1:0]              alarmDetected,
    output liu_regs_pkg::global_cfg_t             globalCfg,
    output logic      [CHANNELS-1:0]              driverHighZ,
    output logic      [CHANNELS*liu_regs_pkg::TEMPLATE_W-1:0] pulseTemplates
);

    //------------------------------------------------------------------------
    // Register state
    //------------------------------------------------------------------------
    logic [7:0]  globalConfiguration_q;  // Global settings, bit 7 held 0.
    logic [liu_regs_pkg::INDEX_W-1:0] templateChannelIndex_q;  // Channel.
    logic [7:0]  driverTristateControl_q;  // One bit per driver.
    logic [7:0]  alarmIrqMask_q;           // One enable per channel.
    logic [7:0]  bankPointer_q;            // Bank selection code.
    logic [CHANNELS-1:0] alarmStatus;      // Held alarm levels.
    logic [CHANNELS-1:0] alarmIrqStatus;   // Sticky change flags.
    logic [liu_regs_pkg::TEMPLATE_W-1:0] templateRd;  // Indexed code.

    //------------------------------------------------------------------------
    // Decode
    //------------------------------------------------------------------------
    logic primaryOpen;       // Primary bank is reachable.
    logic wrGlobal;          // Write strobes, one per writable register.
    logic wrIndex;
    logic wrTemplate;
    logic wrDriver;
    logic wrMask;
    logic wrPointer;
    logic rdStatus;          // Read of the alarm status register.
    logic hit;               // Address belongs to this block.
    logic [7:0] rdData_d;    // Data for the read register.

    // The pointer stays reachable in either bank, otherwise software could
    // never return from the expanded bank. Other registers answer only
    // while the primary bank is selected.
    assign primaryOpen = (bankPointer_q != liu_regs_pkg::BANK_EXPANDED);

    // Address decoding as a priority chain; one strobe at most is high.
    always_comb
    begin
        wrGlobal   = 1'b0;
        wrIndex    = 1'b0;
        wrTemplate = 1'b0;
        wrDriver   = 1'b0;
        wrMask     = 1'b0;
        wrPointer  = 1'b0;
        rdStatus   = 1'b0;
        hit        = 1'b1;
        rdData_d   = 8'h00;
        if (hostReq.addr == liu_regs_pkg::BANK_POINTER_OFFSET)
        begin
            // Bank switch register, both banks.
            wrPointer = hostReq.wrEn;
            rdData_d  = bankPointer_q;
        end
        else if (!primaryOpen)
        begin
            // Expanded bank owns every other address.
            hit = 1'b0;
        end
        else if (hostReq.addr == liu_regs_pkg::GLOBAL_CFG_OFFSET)
        begin
            wrGlobal = hostReq.wrEn;
            rdData_d = globalConfiguration_q;
        end
        else if (hostReq.addr == liu_regs_pkg::TEMPLATE_INDEX_OFFSET)
        begin
            // Upper bits are reserved and read as zero.
            wrIndex  = hostReq.wrEn;
            rdData_d = {5'h00, templateChannelIndex_q};
        end
        else if (hostReq.addr == liu_regs_pkg::PULSE_TEMPLATE_OFFSET)
        begin
            // Acts on the channel named by the index register.
            wrTemplate = hostReq.wrEn;
            rdData_d   = {5'h00, templateRd};
        end
        else if (hostReq.addr == liu_regs_pkg::DRIVER_TRISTATE_OFFSET)
        begin
            wrDriver = hostReq.wrEn;
            rdData_d = driverTristateControl_q;
        end
        else if (hostReq.addr == liu_regs_pkg::ALARM_STATUS_OFFSET)
        begin
            // Read-only; the read itself clears the sticky flags.
            rdStatus = hostReq.rdEn;
            rdData_d = alarmStatus;
        end
        else if (hostReq.addr == liu_regs_pkg::ALARM_MASK_OFFSET)
        begin
            wrMask   = hostReq.wrEn;
            rdData_d = alarmIrqMask_q;
        end
        else if (hostReq.addr == liu_regs_pkg::ALARM_IRQ_OFFSET)
        begin
            // Read-only; writes fall through unused.
            rdData_d = alarmIrqStatus;
        end
        else
        begin
            // Unmapped here; another bank slice may answer.
            hit = 1'b0;
        end
    end

    //------------------------------------------------------------------------
    // Global configuration
    //------------------------------------------------------------------------
    // Bit 7 is forced to zero so the reserved position never holds a one.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            globalConfiguration_q <= liu_regs_pkg::GLOBAL_CFG_RESET;
        else if (ce && wrGlobal)
            globalConfiguration_q <= {1'b0, hostReq.wrData[6:0]};
    end

    //------------------------------------------------------------------------
    // Template channel index
    //------------------------------------------------------------------------
    // Only the three channel bits are kept; bits 7 to 3 stay zero.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            templateChannelIndex_q <= liu_regs_pkg::TEMPLATE_INDEX_RESET;
        else if (ce && wrIndex)
            templateChannelIndex_q <=
                hostReq.wrData[liu_regs_pkg::INDEX_W-1:0];
    end

    //------------------------------------------------------------------------
    // Driver high-impedance control
    //------------------------------------------------------------------------
    // Resetting to zero leaves every driver on the line.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            driverTristateControl_q <= liu_regs_pkg::DRIVER_TRISTATE_RESET;
        else if (ce && wrDriver)
            driverTristateControl_q <= hostReq.wrData;
    end

    // A one on bit n releases driver n into high impedance.
    assign driverHighZ = driverTristateControl_q[CHANNELS-1:0];

    //------------------------------------------------------------------------
    // Alarm mask
    //------------------------------------------------------------------------
    // Reset blocks every channel's alarm event.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            alarmIrqMask_q <= liu_regs_pkg::ALARM_MASK_RESET;
        else if (ce && wrMask)
            alarmIrqMask_q <= hostReq.wrData;
    end

    //------------------------------------------------------------------------
    // Bank pointer
    //------------------------------------------------------------------------
    // Any written value is kept and read back; only the expanded code
    // moves the bank, so stray values behave like the primary code.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            bankPointer_q <= liu_regs_pkg::BANK_POINTER_RESET;
        else if (ce && wrPointer)
            bankPointer_q <= hostReq.wrData;
    end

    assign expandedBankSel = !primaryOpen;

    //------------------------------------------------------------------------
    // Host read answer
    //------------------------------------------------------------------------
    // Data, valid and hit come one cycle after the read strobe.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdData  <= 8'h00;
            rdValid <= 1'b0;
            rdHit   <= 1'b0;
        end
        else if (ce)
        begin
            rdValid <= hostReq.rdEn;
            rdHit   <= hostReq.rdEn && hit;
            // Misses return zero so a shared bus can OR the slices.
            if (hostReq.rdEn && hit)
                rdData <= rdData_d;
            else
                rdData <= 8'h00;
        end
    end

    //------------------------------------------------------------------------
    // Template storage
    //------------------------------------------------------------------------
    // Reserved template codes are stored as written; the line side
    // decides how to treat them.
    template_store #(
        .CHANNELS (CHANNELS),
        .WIDTH    (liu_regs_pkg::TEMPLATE_W),
        .INDEX_W  (liu_regs_pkg::INDEX_W)
    ) u_templates (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .ce       (ce),
        .wrEn     (wrTemplate),
        .index    (templateChannelIndex_q),
        .wrData   (hostReq.wrData[liu_regs_pkg::TEMPLATE_W-1:0]),
        .rdData   (templateRd),
        .allCodes (pulseTemplates)
    );

    //------------------------------------------------------------------------
    // Alarm status and change flags
    //------------------------------------------------------------------------
    alarm_event_detect #(
        .CHANNELS (CHANNELS)
    ) u_alarm (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .ce       (ce),
        .alarmIn  (alarmDetected),
        .mask     (alarmIrqMask_q[CHANNELS-1:0]),
        .clearAll (rdStatus),
        .status   (alarmStatus),
        .sticky   (alarmIrqStatus)
    );

    //------------------------------------------------------------------------
    // Decoded global settings
    //------------------------------------------------------------------------
    // Settings are pure decodes of flops, so they change the cycle after
    // the write and never glitch between writes.
    always_comb
    begin
        globalCfg.alarmInsertOnSignalLoss =
            globalConfiguration_q[liu_regs_pkg::ALARM_INSERT_BIT];
        globalCfg.shortCircuitGuardOff =
            globalConfiguration_q[liu_regs_pkg::GUARD_OFF_BIT];
        globalCfg.lineCodeAmi =
            globalConfiguration_q[liu_regs_pkg::LINE_CODE_BIT];
        // Depth in bits of the attenuator's elastic store.
        if (globalConfiguration_q[liu_regs_pkg::FIFO_DEPTH_BIT])
            globalCfg.attenuatorFifoBits = liu_regs_pkg::FIFO_BITS_DEEP;
        else
            globalCfg.attenuatorFifoBits = liu_regs_pkg::FIFO_BITS_SHALLOW;
        // High selects 5 Hz for T1 and 6.5 Hz for E1; low the lower corners.
        globalCfg.attenuatorBandwidthHigh =
            globalConfiguration_q[liu_regs_pkg::BANDWIDTH_BIT];
        // Codes 00 and 10 both leave the attenuator out of either path.
        globalCfg.attenuatorInTransmit =
            (globalConfiguration_q[liu_regs_pkg::PLACEMENT_LSB +:
                liu_regs_pkg::PLACEMENT_W] == liu_regs_pkg::PLACE_TRANSMIT);
        globalCfg.attenuatorInReceive =
            (globalConfiguration_q[liu_regs_pkg::PLACEMENT_LSB +:
                liu_regs_pkg::PLACEMENT_W] == liu_regs_pkg::PLACE_RECEIVE);
    end

endmodule // liu_global_template_alarm_regs

// file: src/liu_regs_pkg.sv
//----------------------------------------------------------------------------
// Purpose: Shared constants and carriers of the line interface register bank.
// Assumes: Eight channels, byte-wide host port, one register per address.
// Notes:   Every offset, field position, reset value and code lives here.
//----------------------------------------------------------------------------
package liu_regs_pkg;

    //------------------------------------------------------------------------
    // Sizes
    //------------------------------------------------------------------------
    localparam int CHANNELS   = 8;   // Line channels served by the bank.
    localparam int ADDR_W     = 8;   // Host address width.
    localparam int DATA_W     = 8;   // Host data width.
    localparam int INDEX_W    = 3;   // Width of the channel index field.
    localparam int TEMPLATE_W = 3;   // Width of the pulse template code.

    //------------------------------------------------------------------------
    // Register offsets in the primary bank
    //------------------------------------------------------------------------
    localparam logic [7:0] GLOBAL_CFG_OFFSET      = 8'h0F;
    localparam logic [7:0] TEMPLATE_INDEX_OFFSET  = 8'h10;
    localparam logic [7:0] PULSE_TEMPLATE_OFFSET  = 8'h11;
    localparam logic [7:0] DRIVER_TRISTATE_OFFSET = 8'h12;
    localparam logic [7:0] ALARM_STATUS_OFFSET    = 8'h13;
    localparam logic [7:0] ALARM_MASK_OFFSET      = 8'h14;
    localparam logic [7:0] ALARM_IRQ_OFFSET       = 8'h15;
    localparam logic [7:0] BANK_POINTER_OFFSET    = 8'h1F;

    //------------------------------------------------------------------------
    // Field positions of the global configuration register
    //------------------------------------------------------------------------
    localparam int ALARM_INSERT_BIT = 6;  // Alarm insertion on signal loss.
    localparam int GUARD_OFF_BIT    = 5;  // Short-circuit guard disable.
    localparam int LINE_CODE_BIT    = 4;  // Zero-substitution or AMI.
    localparam int FIFO_DEPTH_BIT   = 3;  // Attenuator store depth.
    localparam int BANDWIDTH_BIT    = 2;  // Attenuator corner frequency.
    localparam int PLACEMENT_LSB    = 0;  // Attenuator placement field.
    localparam int PLACEMENT_W      = 2;

    //------------------------------------------------------------------------
    // Reset values
    //------------------------------------------------------------------------
    localparam logic [7:0] GLOBAL_CFG_RESET      = 8'h00;
    localparam logic [2:0] TEMPLATE_INDEX_RESET  = 3'h0;
    localparam logic [2:0] PULSE_TEMPLATE_RESET  = 3'h0;
    localparam logic [7:0] DRIVER_TRISTATE_RESET = 8'h00;
    localparam logic [7:0] ALARM_STATUS_RESET    = 8'h00;
    localparam logic [7:0] ALARM_MASK_RESET      = 8'h00;
    localparam logic [7:0] ALARM_IRQ_RESET       = 8'h00;
    localparam logic [7:0] BANK_POINTER_RESET    = 8'h00;

    //------------------------------------------------------------------------
    // Codes
    //------------------------------------------------------------------------
    localparam logic [7:0] BANK_PRIMARY     = 8'h00;
    localparam logic [7:0] BANK_EXPANDED    = 8'hAA;
    localparam logic [1:0] PLACE_TRANSMIT   = 2'h1;
    localparam logic [1:0] PLACE_RECEIVE    = 2'h3;
    localparam logic [2:0] TEMPLATE_E1      = 3'h0;
    localparam logic [2:0] TEMPLATE_T1_LOW  = 3'h3;
    localparam logic [6:0] FIFO_BITS_SHALLOW = 7'h20;  // 32-bit store.
    localparam logic [6:0] FIFO_BITS_DEEP    = 7'h40;  // 64-bit store.

    //------------------------------------------------------------------------
    // Carriers
    //------------------------------------------------------------------------
    // One host access; write and read strobes last one cycle.
    typedef struct packed {
        logic              wrEn;
        logic              rdEn;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
    } host_req_t;

    // Decoded global settings driving the line-side logic.
    typedef struct packed {
        logic       alarmInsertOnSignalLoss;
        logic       shortCircuitGuardOff;
        logic       lineCodeAmi;
        logic [6:0] attenuatorFifoBits;
        logic       attenuatorBandwidthHigh;
        logic       attenuatorInTransmit;
        logic       attenuatorInReceive;
    } global_cfg_t;

endpackage

// file: src/template_store.sv
//----------------------------------------------------------------------------
// Purpose: Per-channel pulse template codes with one indexed port.
// Assumes: Writes and reads address the same channel index.
// Notes:   Read data come from a register, one cycle behind the index.
//----------------------------------------------------------------------------
`timescale 1ns/1ps
module template_store #(
    parameter int CHANNELS = 8,
    parameter int WIDTH    = 3,
    parameter int INDEX_W  = 3
) (
    input  wire logic                      ref_clk,
    input  wire logic                      nrst,
    input  wire logic                      ce,
    input  wire logic                      wrEn,
    input  wire logic [INDEX_W-1:0]        index,
    input  wire logic [WIDTH-1:0]          wrData,
    output logic      [WIDTH-1:0]          rdData,
    output logic      [CHANNELS*WIDTH-1:0] allCodes
);

    //------------------------------------------------------------------------
    // Storage
    //------------------------------------------------------------------------
    // Each channel keeps its own code; the line side sees all of them.
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_entry
            logic [WIDTH-1:0] code_q;  // This channel's template code.

            // Only the entry named by the index takes a write.
            always_ff @(posedge ref_clk or negedge nrst)
            begin
                if (!nrst)
                    code_q <= liu_regs_pkg::PULSE_TEMPLATE_RESET;
                else if (ce && wrEn && (index == INDEX_W'(ch)))
                    code_q <= wrData;
            end

            assign allCodes[ch*WIDTH +: WIDTH] = code_q;
        end
    endgenerate

    //------------------------------------------------------------------------
    // Registered read port
    //------------------------------------------------------------------------
    // Registering the read costs a cycle after an index change but keeps
    // the wide mux out of the host read path.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            rdData <= liu_regs_pkg::PULSE_TEMPLATE_RESET;
        else if (ce)
            rdData <= allCodes[index*WIDTH +: WIDTH];
    end

endmodule // template_store

// file: src/alarm_event_detect.sv
//----------------------------------------------------------------------------
// Purpose: Samples alarm levels and latches masked changes as sticky flags.
// Assumes: Alarm inputs are synchronous to ref_clk.
// Notes:   A new change wins over a clear in the same cycle.
//----------------------------------------------------------------------------
`timescale 1ns/1ps
module alarm_event_detect #(
    parameter int CHANNELS = 8
) (
    input  wire logic                ref_clk,
    input  wire logic                nrst,
    input  wire logic                ce,
    input  wire logic [CHANNELS-1:0] alarmIn,
    input  wire logic [CHANNELS-1:0] mask,
    input  wire logic                clearAll,
    output logic      [CHANNELS-1:0] status,
    output logic      [CHANNELS-1:0] sticky
);

    //------------------------------------------------------------------------
    // Per-channel detection
    //------------------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_chan
            logic changed;  // Input differs from the held status.

            assign changed = alarmIn[ch] ^ status[ch];

            // The held status is the current alarm level seen by software.
            always_ff @(posedge ref_clk or negedge nrst)
            begin
                if (!nrst)
                    status[ch] <= 1'b0;
                else if (ce)
                    status[ch] <= alarmIn[ch];
            end

            // Either edge of the level sets the flag while allowed.
            always_ff @(posedge ref_clk or negedge nrst)
            begin
                if (!nrst)
                    sticky[ch] <= 1'b0;
                else if (ce)
                begin
                    if (changed && mask[ch])
                        sticky[ch] <= 1'b1;
                    else if (clearAll)
                        sticky[ch] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule // alarm_event_detect

// file: testbench/liu_regs_props.sv
// Purpose: Assertions on the register port and decoded outputs of the bank.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound to every instance of the bank.
`timescale 1ns/1ps
module liu_regs_props #(
    parameter int CHANNELS = 8
) (
    input wire logic                            ref_clk,
    input wire logic                            nrst,
    input wire logic                            ce,
    input wire liu_regs_pkg::host_req_t         hostReq,
    input wire logic [liu_regs_pkg::DATA_W-1:0] rdData,
    input wire logic                            rdValid,
    input wire logic                            rdHit,
    input wire logic                            expandedBankSel,
    input wire liu_regs_pkg::global_cfg_t       globalCfg,
    input wire logic [CHANNELS-1:0]             driverHighZ
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic drvWr;  // A driver register write that the bank accepts.
    logic bankWr; // A pointer write of the expanded-bank code.
    assign drvWr = ce && hostReq.wrEn && !expandedBankSel
        && hostReq.addr == liu_regs_pkg::DRIVER_TRISTATE_OFFSET;
    assign bankWr = ce && hostReq.wrEn && hostReq.wrData == 8'hAA
        && hostReq.addr == liu_regs_pkg::BANK_POINTER_OFFSET;
    sequence readTaken;
        ce && hostReq.rdEn;
    endsequence
    a_read_answer_next: assert property (readTaken |=> rdValid)
        else $error("read answer missing");
    a_no_spurious_valid: assert property (ce && !hostReq.rdEn |=> !rdValid)
        else $error("answer without read");
    a_driver_write_lands: assert property (drvWr |=> driverHighZ == $past(hostReq.wrData))
        else $error("driver bits not written");
    a_driver_holds_idle: assert property (!drvWr |=> $stable(driverHighZ))
        else $error("driver bits changed unasked");
    a_bank_enter_cause: assert property ($rose(expandedBankSel) |-> $past(bankWr))
        else $error("bank switched without pointer write");
    a_expanded_read_miss: assert property (readTaken ##0 (expandedBankSel && hostReq.addr != 8'h1F) |=> !rdHit && rdData == 8'h00)
        else $error("expanded bank read hit here");
    a_fifo_depth_code: assert property (globalCfg.attenuatorFifoBits inside {7'h20, 7'h40})
        else $error("store depth not 32 or 64");
    a_placement_exclusive: assert property (!(globalCfg.attenuatorInTransmit && globalCfg.attenuatorInReceive))
        else $error("attenuator in both paths");
endmodule // liu_regs_props
bind liu_global_template_alarm_regs liu_regs_props #(.CHANNELS(CHANNELS)) props_i (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .hostReq(hostReq), .rdData(rdData), .rdValid(rdValid), .rdHit(rdHit), .expandedBankSel(expandedBankSel), .globalCfg(globalCfg), .driverHighZ(driverHighZ));

// file: testbench/liu_host_model.sv
// Purpose: Host processor model that speaks the bank's strobe protocol.
// Assumes: Strobes launched after a rising edge, dropped once taken.
// Notes:   The idle edge after a write spaces index and template use.
`timescale 1ns/1ps
module liu_host_model (
    input  wire logic               ref_clk,
    input  wire logic [7:0]         rdData,
    output liu_regs_pkg::host_req_t hostReq
);
    initial hostReq = '0;
    // One write; the index is in place before any later template access.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        hostReq <= '{1'h1, 1'h0, a, d};
        @(posedge ref_clk);
        hostReq <= '0;
        // Let the taking edge's update settle before the caller looks.
        @(posedge ref_clk);
    endtask
    // One read; the answer stands for the cycle after the taking edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        hostReq <= '{1'h0, 1'h1, a, 8'h00};
        @(posedge ref_clk);
        hostReq <= '0;
        // Sampled at the edge that closes the answer cycle, before it drops.
        @(posedge ref_clk);
        d = rdData;
    endtask
endmodule // liu_host_model

// file: testbench/liu_global_template_alarm_regs_tb.sv
// Purpose: Register-level tests of the global, template and alarm bank.
// Assumes: 125 MHz clock, reset held six cycles.
// Notes:   Expected values follow the field layout of the package.
`timescale 1ns/1ps
module liu_global_template_alarm_regs_tb;
    logic ref_clk, nrst, ce, rdValid, rdHit, expandedBankSel;
    logic [7:0] alarmDetected, rdData, got, driverHighZ;
    logic [23:0] pulseTemplates, expT;
    liu_regs_pkg::host_req_t hostReq;
    liu_regs_pkg::global_cfg_t globalCfg;
    logic [7:0] regs [8] = '{8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h1F};
    int nFail = 0;
    int checksDone = 0;
    liu_global_template_alarm_regs liu_global_template_alarm_regs_i (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .hostReq(hostReq), .rdData(rdData), .rdValid(rdValid), .rdHit(rdHit), .expandedBankSel(expandedBankSel), .alarmDetected(alarmDetected), .globalCfg(globalCfg), .driverHighZ(driverHighZ), .pulseTemplates(pulseTemplates));
    liu_host_model liu_host_model_i (.ref_clk(ref_clk), .rdData(rdData), .hostReq(hostReq));
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        checksDone++;
        if (g !== e)
        begin
            nFail++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        liu_host_model_i.wr(a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        liu_host_model_i.rd(a, got);
        chk($sformatf("reg %h", a), {16'h0000, e}, {16'h0000, got});
    endtask
    task automatic tallyAndFinish;
        $display("checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'h0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Watchdog: the tests need a few hundred cycles at most.
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        nFail++;
        tallyAndFinish();
    end
    initial
    begin
        nrst = 1'h0;
        ce = 1'h1;
        alarmDetected = 8'h00;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'h1;
        foreach (regs[i]) rc(regs[i], 8'h00);
        chk("cfg", {11'h000, 1'h0, 1'h0, 1'h0, 7'h20, 1'h0, 1'h0, 1'h0}, {11'h000, globalCfg});
        wr(8'h0F, 8'hFF);
        rc(8'h0F, 8'h7F);
        chk("cfg", {11'h000, 1'h1, 1'h1, 1'h1, 7'h40, 1'h1, 1'h0, 1'h1}, {11'h000, globalCfg});
        wr(8'h0F, 8'h54);
        chk("cfg", {11'h000, 1'h1, 1'h0, 1'h1, 7'h20, 1'h1, 1'h0, 1'h0}, {11'h000, globalCfg});
        wr(8'h0F, 8'h21);
        chk("cfg", {11'h000, 1'h0, 1'h1, 1'h0, 7'h20, 1'h0, 1'h1, 1'h0}, {11'h000, globalCfg});
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h10, 8'(i));
            wr(8'h11, 8'hF8 | 8'(7 - i));
            expT[3*i +: 3] = 3'(7 - i);
        end
        chk("templates", expT, pulseTemplates);
        wr(8'h10, 8'hFA);
        rc(8'h10, 8'h02);
        rc(8'h11, 8'h05);
        wr(8'h12, 8'hA5);
        chk("driver", 24'h0000A5, {16'h0000, driverHighZ});
        ce <= 1'h0;
        wr(8'h12, 8'hFF);
        ce <= 1'h1;
        chk("driver", 24'h0000A5, {16'h0000, driverHighZ});
        wr(8'h14, 8'h0F);
        alarmDetected <= 8'h11;
        rc(8'h15, 8'h01);
        rc(8'h13, 8'h11);
        rc(8'h15, 8'h00);
        alarmDetected <= 8'h10;
        rc(8'h15, 8'h01);
        wr(8'h1F, 8'hAA);
        chk("bank", 24'h000001, {23'h000000, expandedBankSel});
        wr(8'h12, 8'h00);
        rc(8'h12, 8'h00);
        rc(8'h1F, 8'hAA);
        wr(8'h1F, 8'h00);
        rc(8'h12, 8'hA5);
        rc(8'h20, 8'h00);
        tallyAndFinish();
    end
endmodule // liu_global_template_alarm_regs_tb
